// >>> design/pwm_load_run_brake_control.sv
// Four-channel PWM control: registers, down counter, load transfer and brake
`default_nettype none

module pwm_load_run_brake_control #(
  parameter int CNT_W = pwm_pkg::CNT_W,
  parameter int CH_N = pwm_pkg::CH_N
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [pwm_pkg::ADDR_W-1:0] addr,
  input wire logic [pwm_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pwm_pkg::DATA_W-1:0] rdata,
  // Brake input pin
  input wire logic brake_pin,
  // PWM outputs
  output logic [CH_N-1:0] pwm_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pwm_pkg::control_a_t con_a_ff;
  pwm_pkg::control_b_t con_b_ff;
  pwm_pkg::control_a_t wr_a;
  logic brake_flag_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] period_buf_ff;
  logic [CNT_W-1:0] period_act_ff;
  logic [CNT_W-1:0] duty_buf_ff [CH_N];
  logic [CNT_W-1:0] duty_act_ff [CH_N];
  logic xfer_done_ff;
  logic [CH_N-1:0] level;
  logic [CH_N-1:0] pwm_out_ff;
  logic [pwm_pkg::DATA_W-1:0] rdata_ff;
  logic [pwm_pkg::DATA_W-1:0] nxt_rdata;
  logic wr_con_a;
  logic wr_con_b;
  logic wr_flag;
  logic wr_per_lo;
  logic wr_per_hi;
  logic underflow;
  logic xfer;
  logic brake_active;
  logic brake_trip;

  assign wr_a = pwm_pkg::control_a_t'(wdata);
  assign wr_con_a = wr && (addr == pwm_pkg::CONTROL_A_OFS);
  assign wr_con_b = wr && (addr == pwm_pkg::CONTROL_B_OFS);
  assign wr_flag = wr && (addr == pwm_pkg::BRAKE_FLAG_OFS);
  assign wr_per_lo = wr && (addr == pwm_pkg::PERIOD_LO_OFS);
  assign wr_per_hi = wr && (addr == pwm_pkg::PERIOD_HI_OFS);

  // Underflow only counts while running, so load alone never transfers
  assign underflow = con_a_ff.counter_go_bit && (cnt_ff == pwm_pkg::CNT_ZERO);
  assign xfer = underflow && con_a_ff.load;

  // ****************************************************************
  // Brake decode and channels
  // ****************************************************************
  pwm_brake_decode u_brake (
    .con_b(con_b_ff),
    .run(con_a_ff.counter_go_bit),
    .brake_pin(brake_pin),
    .brake_active(brake_active),
    .brake_trip(brake_trip)
  );

  for (genvar i = 0; i < CH_N; i++) begin : g_ch
    pwm_compare_channel #(
      .CNT_W(CNT_W)
    ) u_ch (
      .clk(clk),
      .rstn(rstn),
      .run(con_a_ff.counter_go_bit),
      .cnt(cnt_ff),
      .period(period_act_ff),
      .cmp(duty_act_ff[i]),
      .level(level[i])
    );
  end

  // ****************************************************************
  // Down counter
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= pwm_pkg::CNT_ZERO;
    end else if (wr_con_a && wr_a.counter_clear_bit) begin
      cnt_ff <= pwm_pkg::CNT_ZERO;
    end else if (xfer) begin
      cnt_ff <= period_buf_ff;
    end else if (underflow) begin
      cnt_ff <= period_act_ff;
    end else if (con_a_ff.counter_go_bit) begin
      cnt_ff <= cnt_ff - pwm_pkg::CNT_ONE;
    end
  end

  // ****************************************************************
  // Holding registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      period_buf_ff <= pwm_pkg::CNT_ZERO;
    end else if (wr_per_lo) begin
      period_buf_ff[pwm_pkg::DATA_W-1:0] <= wdata;
    end else if (wr_per_hi) begin
      period_buf_ff[CNT_W-1:pwm_pkg::DATA_W] <= wdata[pwm_pkg::HI_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < CH_N; i++) begin
        duty_buf_ff[i] <= pwm_pkg::CNT_ZERO;
      end
    end else if (wr) begin
      for (int i = 0; i < CH_N; i++) begin
        if (addr == pwm_pkg::DUTY_LO_OFS[i]) begin
          duty_buf_ff[i][pwm_pkg::DATA_W-1:0] <= wdata;
        end
        if (addr == pwm_pkg::DUTY_HI_OFS[i]) begin
          duty_buf_ff[i][CNT_W-1:pwm_pkg::DATA_W] <= wdata[pwm_pkg::HI_W-1:0];
        end
      end
    end
  end

  // ****************************************************************
  // Active period and compare registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      period_act_ff <= pwm_pkg::CNT_ZERO;
      for (int i = 0; i < CH_N; i++) begin
        duty_act_ff[i] <= pwm_pkg::CNT_ZERO;
      end
    end else if (xfer) begin
      period_act_ff <= period_buf_ff;
      for (int i = 0; i < CH_N; i++) begin
        duty_act_ff[i] <= duty_buf_ff[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xfer_done_ff <= 1'b0;
    end else begin
      xfer_done_ff <= xfer;
    end
  end

  // ****************************************************************
  // Control A
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      con_a_ff <= pwm_pkg::control_a_t'(pwm_pkg::CONTROL_A_RESET);
    end else begin
      con_a_ff.counter_clear_bit <= 1'b0;
      if (brake_trip) begin
        con_a_ff.counter_go_bit <= 1'b0;
      end else if (wr_con_a) begin
        con_a_ff.counter_go_bit <= wr_a.counter_go_bit;
      end
      if (wr_con_a) begin
        con_a_ff.load <= wr_a.load;
      end else if (xfer_done_ff) begin
        con_a_ff.load <= 1'b0;
      end
      if (underflow) begin
        con_a_ff.underflow_flag <= 1'b1;
      end else if (wr_con_a) begin
        con_a_ff.underflow_flag <= con_a_ff.underflow_flag & wr_a.underflow_flag;
      end
      if (wr_con_a) begin
        con_a_ff.out_invert <= wr_a.out_invert;
      end
    end
  end

  // ****************************************************************
  // Control B and brake flag
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      con_b_ff <= pwm_pkg::control_b_t'(pwm_pkg::CONTROL_B_RESET);
    end else if (wr_con_b) begin
      con_b_ff <= pwm_pkg::control_b_t'(wdata);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      brake_flag_ff <= 1'b0;
    end else if (brake_trip) begin
      brake_flag_ff <= 1'b1;
    end else if (wr_flag) begin
      brake_flag_ff <= brake_flag_ff & wdata[pwm_pkg::BRAKE_FLAG_BIT];
    end
  end

  // ****************************************************************
  // Output stage
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_out_ff <= {CH_N{pwm_pkg::OUT_RESET_LEVEL}};
    end else if (brake_active) begin
      pwm_out_ff <= con_b_ff.out_brake_level;
    end else begin
      pwm_out_ff <= level ^ con_a_ff.out_invert;
    end
  end

  assign pwm_out = pwm_out_ff;

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    nxt_rdata = '0;
    case (addr)
      pwm_pkg::CONTROL_A_OFS: begin
        nxt_rdata = con_a_ff;
      end
      pwm_pkg::CONTROL_B_OFS: begin
        nxt_rdata = con_b_ff;
      end
      pwm_pkg::BRAKE_FLAG_OFS: begin
        nxt_rdata[pwm_pkg::BRAKE_FLAG_BIT] = brake_flag_ff;
      end
      pwm_pkg::PERIOD_LO_OFS: begin
        nxt_rdata = period_buf_ff[pwm_pkg::DATA_W-1:0];
      end
      pwm_pkg::PERIOD_HI_OFS: begin
        nxt_rdata[pwm_pkg::HI_W-1:0] = period_buf_ff[CNT_W-1:pwm_pkg::DATA_W];
      end
      default: begin
        for (int i = 0; i < CH_N; i++) begin
          if (addr == pwm_pkg::DUTY_LO_OFS[i]) begin
            nxt_rdata = duty_buf_ff[i][pwm_pkg::DATA_W-1:0];
          end
          if (addr == pwm_pkg::DUTY_HI_OFS[i]) begin
            nxt_rdata[pwm_pkg::HI_W-1:0] = duty_buf_ff[i][CNT_W-1:pwm_pkg::DATA_W];
          end
        end
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else if (rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata = rdata_ff;

endmodule : pwm_load_run_brake_control

`default_nettype wire

// >>> inc/pwm_pkg.sv
// Constants, register map and field layouts of the four-channel PWM control block
`default_nettype none

package pwm_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int CNT_W = 10;
  localparam int CH_N = 4;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int HI_W = CNT_W - DATA_W;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] PERIOD_LO_OFS = 8'hd9;
  localparam logic [ADDR_W-1:0] PERIOD_HI_OFS = 8'hd1;
  localparam logic [ADDR_W-1:0] CONTROL_A_OFS = 8'hdc;
  localparam logic [ADDR_W-1:0] CONTROL_B_OFS = 8'hdf;
  localparam logic [ADDR_W-1:0] BRAKE_FLAG_OFS = 8'he0;
  localparam logic [ADDR_W-1:0] DUTY_LO_OFS [CH_N] = '{8'hda, 8'hdb, 8'hdd, 8'hde};
  localparam logic [ADDR_W-1:0] DUTY_HI_OFS [CH_N] = '{8'hd2, 8'hd3, 8'hd5, 8'hd6};

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  typedef struct packed {
    logic counter_go_bit;
    logic load;
    logic underflow_flag;
    logic counter_clear_bit;
    logic [CH_N-1:0] out_invert;
  } control_a_t;

  typedef struct packed {
    logic brake_when_idle_select;
    logic brake_input_polarity;
    logic brake_input_select;
    logic brake_master_enable;
    logic [CH_N-1:0] out_brake_level;
  } control_b_t;

  // ****************************************************************
  // Values
  // ****************************************************************
  localparam logic [DATA_W-1:0] CONTROL_A_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CONTROL_B_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [CNT_W-1:0] CMP_ALL_ZERO = 10'h000;
  localparam logic [CNT_W-1:0] CMP_ALL_ONE = 10'h3ff;
  localparam logic OUT_RESET_LEVEL = 1'b1;
  localparam int BRAKE_FLAG_BIT = 0;

endpackage : pwm_pkg

`default_nettype wire

// >>> design/pwm_compare_channel.sv
// One PWM channel: compares the shared counter against its active compare value
`default_nettype none

module pwm_compare_channel #(
  parameter int CNT_W = pwm_pkg::CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Counter state
  input wire logic run,
  input wire logic [CNT_W-1:0] cnt,
  input wire logic [CNT_W-1:0] period,
  input wire logic [CNT_W-1:0] cmp,
  // Uninverted channel level
  output logic level
);

  // ****************************************************************
  // Compare
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      level <= pwm_pkg::OUT_RESET_LEVEL;
    end else if (!run) begin
      level <= level;
    end else if (cmp == pwm_pkg::CMP_ALL_ZERO) begin
      level <= 1'b1;
    end else if (cmp == pwm_pkg::CMP_ALL_ONE) begin
      level <= 1'b0;
    end else if (cmp > period) begin
      level <= 1'b0;
    end else begin
      level <= (cnt >= cmp);
    end
  end

endmodule : pwm_compare_channel

`default_nettype wire

// >>> design/pwm_brake_decode.sv
// Brake decision from control B, the run bit and the brake input pin
`default_nettype none

module pwm_brake_decode (
  // Configuration and state
  input wire pwm_pkg::control_b_t con_b,
  input wire logic run,
  // Brake input pin
  input wire logic brake_pin,
  // Decision
  output logic brake_active,
  output logic brake_trip
);

  logic pin_asserted;

  // ****************************************************************
  // Decode
  // ****************************************************************
  always_comb begin
    pin_asserted = con_b.brake_input_polarity ? brake_pin : !brake_pin;
    brake_active = 1'b0;
    brake_trip = 1'b0;
    if (con_b.brake_master_enable) begin
      case ({con_b.brake_when_idle_select, con_b.brake_input_select})
        2'b00: begin
          brake_active = 1'b1;
        end
        2'b10: begin
          brake_active = !run;
        end
        2'b01: begin
          brake_active = pin_asserted;
          brake_trip = pin_asserted;
        end
        default: begin
          brake_active = 1'b0;
        end
      endcase
    end
  end

endmodule : pwm_brake_decode

`default_nettype wire

// >>> sim/pwm_ctrl_checker.sv
// Port-level assertions for the PWM control block
`default_nettype none

module pwm_ctrl_checker #(
  parameter int CH_N = pwm_pkg::CH_N
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [pwm_pkg::ADDR_W-1:0] addr,
  input wire logic [pwm_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [pwm_pkg::DATA_W-1:0] rdata,
  // Pins
  input wire logic brake_pin,
  input wire logic [CH_N-1:0] pwm_out
);
  pwm_pkg::control_b_t cb_ff;
  logic run_ff;
  logic wr_a;
  logic wr_b;
  logic en;
  logic [1:0] mode;
  logic trip;

  assign wr_a = wr && (addr == pwm_pkg::CONTROL_A_OFS);
  assign wr_b = wr && (addr == pwm_pkg::CONTROL_B_OFS);
  assign en = cb_ff.brake_master_enable;
  assign mode = {cb_ff.brake_when_idle_select, cb_ff.brake_input_select};
  assign trip = en && (mode == 2'b01) && (brake_pin == cb_ff.brake_input_polarity);

  // ************************************************
  // Shadows of control B and of the run bit
  // ************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cb_ff <= '0;
    end else if (wr_b) begin
      cb_ff <= pwm_pkg::control_b_t'(wdata);
    end
  end

  // Pin brake beats a software write of the run bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_ff <= 1'b0;
    end else if (trip) begin
      run_ff <= 1'b0;
    end else if (wr_a) begin
      run_ff <= wdata[7];
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb_clk @(posedge clk);
  endclocking
  default disable iff (!rstn);

  ctrl_b_readback_a: assert property (rd && addr == pwm_pkg::CONTROL_B_OFS |=> rdata == $past(cb_ff))
    else $error("control B read-back differs");
  ctrl_a_readback_a: assert property (wr_a ##2 (rd && addr == pwm_pkg::CONTROL_A_OFS) |=>
    rdata[4:0] == {1'b0, $past(wdata[3:0], 3)})
    else $error("control A invert or clear bit read-back wrong");
  soft_brake_a: assert property (en && mode == 2'b00 |=> pwm_out == $past(cb_ff.out_brake_level))
    else $error("software brake level not driven");
  idle_brake_a: assert property (en && mode == 2'b10 && !run_ff |=> pwm_out == $past(cb_ff.out_brake_level))
    else $error("idle brake level not driven");
  pin_brake_a: assert property (trip |=> pwm_out == $past(cb_ff.out_brake_level))
    else $error("pin brake level not driven");
  trip_stops_run_a: assert property (trip ##1 (rd && addr == pwm_pkg::CONTROL_A_OFS) |=> !rdata[7])
    else $error("pin brake left run set");
  trip_flag_a: assert property (trip ##1 (rd && addr == pwm_pkg::BRAKE_FLAG_OFS) |=> rdata[0])
    else $error("pin brake flag not set");
  idle_freeze_a: assert property ((!run_ff && !en && !wr_a && !wr_b) [*4] |-> $stable(pwm_out))
    else $error("outputs moved while halted");

endmodule // pwm_ctrl_checker

bind pwm_load_run_brake_control pwm_ctrl_checker #(.CH_N(CH_N)) u_checker (
  .clk(clk),
  .rstn(rstn),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .brake_pin(brake_pin),
  .pwm_out(pwm_out)
);

`default_nettype wire

// >>> sim/brake_pin_model.sv
// Behavioural source of the external brake input pin
`default_nettype none

module brake_pin_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Requested level
  input wire logic level,
  // Pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pin changes only after a clock edge, like a synchronised input
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin <= 1'b0;
    end else begin
      pin <= level;
    end
  end
endmodule // brake_pin_model

`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench of the PWM control block
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] DL [4] = '{8'h00, 8'hff, 8'h05, 8'h02};
  localparam logic [7:0] DH [4] = '{8'h00, 8'hff, 8'h00, 8'h00};
  // Brake mode bits are never both set
  localparam logic [7:0] BK_CB [6] = '{8'h05, 8'h15, 8'h95, 8'h35, 8'h35, 8'h75};
  localparam logic BK_PIN [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  localparam logic [3:0] BK_EXP [6] = '{4'h6, 4'h5, 4'h5, 4'h6, 4'h5, 4'h5};

  logic clk;
  logic rstn;
  logic wr;
  logic rd;
  logic pin_lvl;
  logic brake_pin;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [3:0] pwm_out;
  int n_errors = 0;
  int n_compared = 0;

  pwm_load_run_brake_control DUT (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .brake_pin(brake_pin), .pwm_out(pwm_out));
  brake_pin_model u_pin (.clk(clk), .rstn(rstn), .level(pin_lvl), .pin(brake_pin));

  // ************************************************
  // Tasks
  // ************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    check(d, e);
  endtask

  task automatic out_chk(input logic [3:0] m, input logic [3:0] e);
    #1;
    check({4'h0, pwm_out & m}, {4'h0, e & m});
    @(posedge clk);
  endtask

  // Eight cycles: channels 2..0 fixed, channel 3 half high or frozen
  task automatic run_chk(input logic [2:0] e, input logic frz);
    int h;
    h = 0;
    repeat (8) begin
      #1;
      check({5'h0, pwm_out[2:0]}, {5'h0, e});
      h += int'(pwm_out[3] === 1'b1);
      @(posedge clk);
    end
    check(8'(frz ? h % 8 : h), frz ? 8'h00 : 8'h04);
  endtask

  // ************************************************
  // Clock, watchdog and test sequence
  // ************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // The sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    int k;
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    pin_lvl = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk(pwm_pkg::CONTROL_A_OFS, 8'h00);
    rd_chk(pwm_pkg::CONTROL_B_OFS, 8'h00);
    rd_chk(8'he1, 8'h00);
    out_chk(4'hf, 4'hf);
    wr_reg(pwm_pkg::PERIOD_LO_OFS, 8'h03);
    wr_reg(pwm_pkg::PERIOD_HI_OFS, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr_reg(pwm_pkg::DUTY_LO_OFS[i], DL[i]);
      wr_reg(pwm_pkg::DUTY_HI_OFS[i], DH[i]);
    end
    rd_chk(pwm_pkg::DUTY_HI_OFS[1], 8'h03);
    rd_chk(pwm_pkg::DUTY_LO_OFS[3], 8'h02);
    wr_reg(pwm_pkg::CONTROL_A_OFS, 8'h40);
    repeat (5) @(posedge clk);
    rd_chk(pwm_pkg::CONTROL_A_OFS, 8'h40);
    out_chk(4'hf, 4'hf);
    wr_reg(pwm_pkg::CONTROL_A_OFS, 8'hc0);
    k = 0;
    do begin
      rd_reg(pwm_pkg::CONTROL_A_OFS, d);
      k++;
    end while (d[6] !== 1'b0 && k < 20);
    check(d, 8'ha0);
    run_chk(3'b001, 1'b0);
    wr_reg(pwm_pkg::CONTROL_A_OFS, 8'h8f);
    repeat (2) @(posedge clk);
    run_chk(3'b110, 1'b0);
    wr_reg(pwm_pkg::CONTROL_A_OFS, 8'h3f);
    rd_chk(pwm_pkg::CONTROL_A_OFS, 8'h2f);
    run_chk(3'b110, 1'b1);
    for (int i = 0; i < 6; i++) begin
      pin_lvl <= BK_PIN[i];
      wr_reg(pwm_pkg::CONTROL_B_OFS, BK_CB[i]);
      @(posedge clk);
      out_chk(4'h7, BK_EXP[i]);
    end
    rd_chk(pwm_pkg::BRAKE_FLAG_OFS, 8'h01);
    pin_lvl <= 1'b0;
    repeat (2) @(posedge clk);
    wr_reg(pwm_pkg::BRAKE_FLAG_OFS, 8'h00);
    rd_chk(pwm_pkg::BRAKE_FLAG_OFS, 8'h00);
    wr_reg(pwm_pkg::CONTROL_B_OFS, 8'h95);
    wr_reg(pwm_pkg::CONTROL_A_OFS, 8'h8f);
    repeat (2) @(posedge clk);
    run_chk(3'b110, 1'b0);
    pin_lvl <= 1'b1;
    wr_reg(pwm_pkg::CONTROL_B_OFS, 8'h75);
    repeat (2) @(posedge clk);
    out_chk(4'hf, 4'h5);
    rd_chk(pwm_pkg::CONTROL_A_OFS, 8'h2f);
    // Long active period, then a pending load cancelled before its underflow
    pin_lvl <= 1'b0;
    wr_reg(pwm_pkg::CONTROL_B_OFS, 8'h05);
    wr_reg(pwm_pkg::PERIOD_LO_OFS, 8'hff);
    wr_reg(pwm_pkg::CONTROL_A_OFS, 8'hdf);
    repeat (4) @(posedge clk);
    rd_chk(pwm_pkg::CONTROL_A_OFS, 8'haf);
    wr_reg(pwm_pkg::PERIOD_LO_OFS, 8'h03);
    wr_reg(pwm_pkg::CONTROL_A_OFS, 8'hef);
    wr_reg(pwm_pkg::CONTROL_A_OFS, 8'haf);
    repeat (300) @(posedge clk);
    wr_reg(pwm_pkg::CONTROL_A_OFS, 8'h8f);
    repeat (8) @(posedge clk);
    // A short period would have set the flag again by now
    rd_chk(pwm_pkg::CONTROL_A_OFS, 8'h8f);
    print_verdict();
  end
endmodule // testbench

`default_nettype wire
